// >>> mfm_read_separator.sv
/*
 * MFM read separator: bit-clock divider with hold, window-extension
 * data/clock split, address-mark detector and run-length detector.
 * Assumes raw pulses and the 2x oscillator arrive asynchronously on pins
 * and are far slower than clk; software drives the APB port.
 */
// Design decisions made here: the register addresses and the APB slave port.
//
// Behaviour
// - Bit clock comes from dividing the double-rate oscillator by two.
// - Pulse edge moved to mid half-cycle, held until the next bit edge.
// - Pulse in true phase is data; pulse in inverted phase is clock.
// - Data latch set and cleared by true phase; clock latch by inverted.
// - Second latch stage on opposite edge yields NRZ data and NRZ clocks.
// - Pulses may jitter a quarter bit period without loss.
// - While phase unresolved, inverted-phase pulses count as data.
// - Divider held in reset, no bit clocks, while hunt line low.
// - After hunt rises, next pulse edge releases divider in clock phase.
// - Phase relation stays fixed after release for the whole field.
// - Hunt line falling resets divider and stops bit clocks.
// - Sync mark is data A1 with clock 0A; clock 0E must not match.
// - After release data output high, clock output low; phases shift streams.
// - Data shifted on inverted falling edge, clocks on true falling edge.
// - Mark latch sets only when both registers match together.
// - Mark signal starts conversion; clock stream unused afterwards.
// - Mark signal stays asserted until hunt line falls.
// - Mark edge retimed to rising bit edge, then delayed one bit.
// - Steady run reported after 16 consecutive pulses inside the window.
`timescale 1ns/1ps
module mfm_read_separator #(
   parameter int unsigned ONE_SHOT_CYCLES = mfm_pkg::ONE_SHOT_CYC,
   parameter int unsigned RUN_PULSES = mfm_pkg::RUN_PULSES
) (
   input wire logic clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [mfm_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Pins
   input wire logic rawPulse,
   input wire logic oscillator_out_n,
   output logic bitClk,
   output logic bitClkN,
   output logic separated_read_data_n,
   output logic separated_clock_bits_n,
   output logic mark_found_n,
   output logic steady_run_detect,
   output logic divider_hold_n
);

   localparam int unsigned GAP_W = $clog2(ONE_SHOT_CYCLES + 1);
   localparam int unsigned RUN_W = $clog2(RUN_PULSES + 1);
   localparam int unsigned SW = mfm_pkg::SHIFT_W;

   // Input synchronisers
   logic [1:0] pulseSync_reg;
   logic [1:0] oscSync_reg;
   logic pulseLast_reg;
   logic oscLast_reg;
   logic pulseEdge;
   logic oscTick;
   logic oscMid;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pulseSync_reg <= 2'h0;
         oscSync_reg <= 2'h3;
         pulseLast_reg <= 1'b0;
         oscLast_reg <= 1'b1;
      end else begin
         pulseSync_reg <= {pulseSync_reg[0], rawPulse};
         oscSync_reg <= {oscSync_reg[0], oscillator_out_n};
         pulseLast_reg <= pulseSync_reg[1];
         oscLast_reg <= oscSync_reg[1];
      end
   end

   assign pulseEdge = pulseSync_reg[1] && !pulseLast_reg;
   // Oscillator rising edge is the falling edge of the active-low pin
   assign oscTick = !oscSync_reg[1] && oscLast_reg;
   assign oscMid = oscSync_reg[1] && !oscLast_reg;

   // Control register
   mfm_pkg::mfm_ctrl_t ctrl_reg;
   logic huntLine;
   logic readEn;

   assign huntLine = ctrl_reg.mark_hunt_line;
   assign readEn = ctrl_reg.readEnable;

   // Divider hold sequence
   mfm_pkg::mfm_div_state_t divState_reg;
   mfm_pkg::mfm_div_state_t divState_next;
   logic running;

   always_comb begin
      divState_next = divState_reg;
      unique case (divState_reg)
         mfm_pkg::DIV_HELD: begin
            if (huntLine) begin
               divState_next = mfm_pkg::DIV_ARMED;
            end
         end
         mfm_pkg::DIV_ARMED: begin
            if (!huntLine) begin
               divState_next = mfm_pkg::DIV_HELD;
            end else if (pulseEdge) begin
               divState_next = mfm_pkg::DIV_RUN;
            end
         end
         mfm_pkg::DIV_RUN: begin
            if (!huntLine) begin
               divState_next = mfm_pkg::DIV_HELD;
            end
         end
         default: divState_next = mfm_pkg::DIV_HELD;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         divState_reg <= mfm_pkg::DIV_HELD;
      end else begin
         divState_reg <= divState_next;
      end
   end

   assign running = (divState_reg == mfm_pkg::DIV_RUN);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         divider_hold_n <= 1'b0;
      end else begin
         divider_hold_n <= (divState_next == mfm_pkg::DIV_RUN);
      end
   end

   // Bit-clock divider
   logic releaseNow;
   logic bitRise;
   logic bitFall;

   assign releaseNow = (divState_reg == mfm_pkg::DIV_ARMED) && huntLine &&
      pulseEdge;
   assign bitRise = running && oscTick && !bitClk;
   assign bitFall = running && oscTick && bitClk;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bitClk <= 1'b0;
         bitClkN <= 1'b1;
      end else if (!running || releaseNow || !huntLine) begin
         // Held, and on release the inverted phase is high
         bitClk <= 1'b0;
         bitClkN <= 1'b1;
      end else if (oscTick) begin
         bitClk <= !bitClk;
         bitClkN <= bitClk;
      end
   end

   // Window extension: pulse waits for mid half-cycle before capture
   logic pending_reg;
   logic classify;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pending_reg <= 1'b0;
      end else if (pulseEdge) begin
         pending_reg <= 1'b1;
      end else if (oscMid) begin
         pending_reg <= 1'b0;
      end
   end

   // Half an oscillator period of slack either side gives quarter-bit jitter
   assign classify = pending_reg && oscMid;

   logic dataCap_reg;
   logic clockCap_reg;
   logic dataNrz_reg;
   logic clockNrz_reg;

   // First latch stage
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dataCap_reg <= 1'b0;
         clockCap_reg <= 1'b0;
      end else if (!running) begin
         // Unresolved phase: any pulse is taken as data
         dataCap_reg <= dataCap_reg || classify;
         clockCap_reg <= 1'b0;
      end else begin
         if (bitFall) begin
            dataCap_reg <= 1'b0;
         end else if (classify && bitClk) begin
            dataCap_reg <= 1'b1;
         end
         if (bitRise) begin
            clockCap_reg <= 1'b0;
         end else if (classify && bitClkN) begin
            clockCap_reg <= 1'b1;
         end
      end
   end

   // Second latch stage, opposite edges
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dataNrz_reg <= 1'b0;
         clockNrz_reg <= 1'b1;
      end else if (!running) begin
         dataNrz_reg <= 1'b0;
         clockNrz_reg <= 1'b1;
      end else begin
         if (bitFall) begin
            dataNrz_reg <= dataCap_reg || (classify && bitClk);
         end
         if (bitRise) begin
            clockNrz_reg <= clockCap_reg || (classify && bitClkN);
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         separated_read_data_n <= 1'b1;
         separated_clock_bits_n <= 1'b0;
      end else begin
         separated_read_data_n <= !(dataNrz_reg && running && huntLine);
         separated_clock_bits_n <= !(clockNrz_reg || !running || !huntLine);
      end
   end

   // Mark detector shift registers
   logic [SW-1:0] dataShift_reg;
   logic [SW-1:0] clockShift_reg;
   logic mark_found_latch;
   logic markMatch;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dataShift_reg <= '0;
      end else if (!running) begin
         dataShift_reg <= '0;
      end else if (bitRise) begin
         // Falling edge of the inverted phase
         dataShift_reg <= {dataShift_reg[SW-2:0], dataNrz_reg};
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clockShift_reg <= '0;
      end else if (!running) begin
         clockShift_reg <= '0;
      end else if (bitFall && !mark_found_latch) begin
         // Clock stream dropped once the mark is found
         clockShift_reg <= {clockShift_reg[SW-2:0], clockNrz_reg};
      end
   end

   assign markMatch = (dataShift_reg == mfm_pkg::MARK_DATA) &&
      (clockShift_reg == mfm_pkg::MARK_CLOCK);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mark_found_latch <= 1'b0;
      end else if (!huntLine) begin
         mark_found_latch <= 1'b0;
      end else if (running && markMatch) begin
         mark_found_latch <= 1'b1;
      end
   end

   // Retime to rising bit edge, then one more bit of delay
   logic markRetimed_reg;
   logic markDelayed_reg;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         markRetimed_reg <= 1'b0;
         markDelayed_reg <= 1'b0;
      end else if (!huntLine) begin
         markRetimed_reg <= 1'b0;
         markDelayed_reg <= 1'b0;
      end else if (bitRise) begin
         markRetimed_reg <= mark_found_latch;
         markDelayed_reg <= markRetimed_reg;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mark_found_n <= 1'b1;
      end else begin
         mark_found_n <= !(markDelayed_reg && huntLine);
      end
   end

   // Run-length detector: retriggerable window and pulse counter
   logic [GAP_W-1:0] gapCnt_reg;
   logic [RUN_W-1:0] runCnt_reg;
   logic windowLive_reg;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gapCnt_reg <= '0;
         windowLive_reg <= 1'b0;
         runCnt_reg <= '0;
      end else if (!readEn) begin
         gapCnt_reg <= '0;
         windowLive_reg <= 1'b0;
         runCnt_reg <= '0;
      end else if (pulseEdge) begin
         gapCnt_reg <= '0;
         windowLive_reg <= 1'b1;
         if (!windowLive_reg) begin
            runCnt_reg <= RUN_W'(1);
         end else if (runCnt_reg != RUN_W'(RUN_PULSES)) begin
            runCnt_reg <= runCnt_reg + RUN_W'(1);
         end
      end else if (windowLive_reg) begin
         if (gapCnt_reg == GAP_W'(ONE_SHOT_CYCLES)) begin
            // Window expired: one-shot drops and clears the count
            windowLive_reg <= 1'b0;
            runCnt_reg <= '0;
         end else begin
            gapCnt_reg <= gapCnt_reg + GAP_W'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         steady_run_detect <= 1'b0;
      end else if (!readEn) begin
         steady_run_detect <= 1'b0;
      end else if (runCnt_reg == RUN_W'(RUN_PULSES)) begin
         // Latched; software polls it before raising the hunt line
         steady_run_detect <= 1'b1;
      end
   end

   // APB slave, one wait state
   logic apbAccess;
   logic apbCommit;
   logic addrHit;
   mfm_pkg::mfm_status_t status;

   assign apbAccess = psel && penable && !pready;
   assign apbCommit = psel && penable && pready;
   assign addrHit = (paddr == mfm_pkg::ADDR_CTRL) ||
      (paddr == mfm_pkg::ADDR_STATUS) || (paddr == mfm_pkg::ADDR_SHIFT);

   always_comb begin
      status = '0;
      status.steady_run_detect = steady_run_detect;
      status.divider_hold_n = divider_hold_n;
      status.mark_found_latch = mark_found_latch;
      status.markAligned = !mark_found_n;
      status.bitPhase = bitClk;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apbAccess;
         pslverr <= apbAccess && !addrHit;
         if (apbAccess && !pwrite) begin
            unique case (paddr)
               mfm_pkg::ADDR_CTRL: prdata <= ctrl_reg;
               mfm_pkg::ADDR_STATUS: prdata <= status;
               mfm_pkg::ADDR_SHIFT: begin
                  prdata <= '0;
                  prdata[mfm_pkg::SHIFT_DATA_LSB +: SW] <= dataShift_reg;
                  prdata[mfm_pkg::SHIFT_CLOCK_LSB +: SW] <= clockShift_reg;
               end
               default: prdata <= 32'h0000_0000;
            endcase
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_reg <= mfm_pkg::CTRL_RESET;
      end else if (apbCommit && pwrite && pstrb[0] &&
            paddr == mfm_pkg::ADDR_CTRL) begin
         ctrl_reg.mark_hunt_line <= pwdata[0];
         ctrl_reg.readEnable <= pwdata[1];
      end
   end

endmodule : mfm_read_separator

// >>> mfm_pkg.sv
/*
 * Constants, types and register map of the MFM read separator and
 * address-mark detector.
 * Assumes a 100 MHz system clock and an APB register port.
 */
package mfm_pkg;

   // System clock
   localparam int unsigned CLK_PERIOD_NS = 10;

   // Run-length one-shot window, 1.25 bit periods at a 5 MHz bit rate
   localparam int unsigned ONE_SHOT_NS = 250;
   localparam int unsigned ONE_SHOT_CYC = ONE_SHOT_NS / CLK_PERIOD_NS;
   localparam int unsigned RUN_PULSES = 16;

   // Sync mark patterns
   localparam logic [7:0] MARK_DATA = 8'hA1;
   localparam logic [7:0] MARK_CLOCK = 8'h0A;
   localparam int unsigned SHIFT_W = 8;

   // APB register map (byte addresses)
   localparam int unsigned ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_SHIFT = 12'h008;

   // Shift register readback layout
   localparam int unsigned SHIFT_DATA_LSB = 0;
   localparam int unsigned SHIFT_CLOCK_LSB = 8;

   typedef struct packed {
      logic [29:0] reserved;
      logic readEnable;
      logic mark_hunt_line;
   } mfm_ctrl_t;

   localparam mfm_ctrl_t CTRL_RESET = '0;

   typedef struct packed {
      logic [26:0] reserved;
      logic bitPhase;
      logic markAligned;
      logic mark_found_latch;
      logic divider_hold_n;
      logic steady_run_detect;
   } mfm_status_t;

   // Divider hold sequence
   typedef enum logic [1:0] {
      DIV_HELD = 2'b00,
      DIV_ARMED = 2'b01,
      DIV_RUN = 2'b10
   } mfm_div_state_t;

endpackage : mfm_pkg

// >>> mfm_properties.sv
/* Concurrent checks on the read separator pins.
   Bound to mfm_read_separator from the bench top; one clock domain. */
`timescale 1ns/1ps
module mfm_properties (
   input wire logic clk,
   input wire logic reset,
   input wire logic bitClk,
   input wire logic bitClkN,
   input wire logic separated_read_data_n,
   input wire logic separated_clock_bits_n,
   input wire logic mark_found_n,
   input wire logic divider_hold_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   held_clock_a: assert property (!divider_hold_n |-> !bitClk)
      else $error("bit clock runs while held");
   held_streams_a: assert property (!divider_hold_n |->
      separated_read_data_n && !separated_clock_bits_n)
      else $error("streams not parked while held");
   phase_pair_a: assert property (bitClkN == !bitClk)
      else $error("bit clock phases not complementary");
   half_bit_a: assert property ($rose(bitClk) |=>
      (bitClk || !divider_hold_n) [*4])
      else $error("bit clock half period too short");
   mark_cleared_a: assert property (!divider_hold_n &&
      !$past(divider_hold_n) |-> mark_found_n)
      else $error("mark active while divider held");
   mark_kept_a: assert property ($rose(mark_found_n) |->
      ##[0:3] !divider_hold_n)
      else $error("mark dropped without hunt falling");
   mark_retimed_a: assert property ($fell(mark_found_n) |->
      bitClk && !$past(bitClk, 3))
      else $error("mark edge not on bit clock rise");
   data_edge_a: assert property (divider_hold_n &&
      $past(divider_hold_n, 3) && $changed(separated_read_data_n)
      |-> !bitClk && $past(bitClk, 3))
      else $error("data output moved off falling phase");
   clock_edge_a: assert property (divider_hold_n &&
      $past(divider_hold_n, 3) && $changed(separated_clock_bits_n)
      |-> bitClk && !$past(bitClk, 3))
      else $error("clock output moved off rising phase");
endmodule : mfm_properties

// >>> mfm_drive_model.sv
/* Drive read channel model: double-rate oscillator pin and MFM pulses.
   Assumes the bench queues bytes and supplies a pulse offset. */
`timescale 1ns/1ps
module mfm_drive_model (
   input wire logic clk,
   input wire logic streamOn,
   input wire logic sendByte,
   input wire logic [7:0] byteData,
   input wire logic [7:0] byteClk,
   input wire logic [1:0] jitter,
   output logic oscillator_out_n,
   output logic rawPulse
);
   logic cells[$];
   int phase = 0;
   int offs = 0;
   logic cur = 1'b0;
   initial begin
      oscillator_out_n = 1'b1;
      rawPulse = 1'b0;
   end
   // Half cell is one oscillator period of 10 clk
   always @(posedge clk) begin
      if (sendByte) begin
         for (int i = 7; i >= 0; i--) begin
            cells.push_back(byteClk[i]);
            cells.push_back(byteData[i]);
         end
      end
      phase <= (phase == 9) ? 0 : phase + 1;
      oscillator_out_n <= (phase >= 4 && phase != 9);
      if (phase == 9) begin
         // Zeros carry a clock pulse in every bit cell
         if (cells.size() == 0 && streamOn) begin
            cells.push_back(1'b1);
            cells.push_back(1'b0);
         end
         cur <= (cells.size() > 0) ? cells.pop_front() : 1'b0;
         offs <= jitter % 3;
      end
      rawPulse <= cur && phase >= offs && phase < offs + 3;
   end
endmodule : mfm_drive_model

// >>> mfm_read_separator_mark_detect_tb_top.sv
/* Bench top: APB master, drive model, watchdog and scenario checks.
   Assumes a 100 MHz clock and the mfm_pkg register map. */
`timescale 1ns/1ps
module mfm_read_separator_mark_detect_tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [mfm_pkg::ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, rawPulse, oscillator_out_n, bitClk, bitClkN;
   logic separated_read_data_n, separated_clock_bits_n, mark_found_n;
   logic steady_run_detect, divider_hold_n, e;
   logic [31:0] prdata, rd, w;
   logic streamOn = 1'b0;
   logic sendByte = 1'b0;
   logic [7:0] byteData = 8'h00;
   logic [7:0] byteClk = 8'h00;
   logic [1:0] jitter = 2'h0;
   int seed = 28;
   int n_fail = 0;
   int cmp_count = 0;
   int cnt;

   always #5 clk = ~clk;
   always @(posedge clk) jitter <= 2'($random(seed));

   mfm_read_separator u_dut (.clk, .reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .rawPulse,
      .oscillator_out_n, .bitClk, .bitClkN, .separated_read_data_n,
      .separated_clock_bits_n, .mark_found_n, .steady_run_detect,
      .divider_hold_n);
   mfm_drive_model u_drive (.clk, .streamOn, .sendByte, .byteData,
      .byteClk, .jitter, .oscillator_out_n, .rawPulse);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_fail++;
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic ctrl(input logic [1:0] v);
      apb(1'b1, mfm_pkg::ADDR_CTRL, {30'h0, v}, 4'hF);
   endtask : ctrl

   task automatic wait_for(ref logic sig, input logic val, input int lim);
      cnt = 0;
      while (sig !== val && cnt < lim) begin
         @(posedge clk);
         cnt++;
      end
   endtask : wait_for

   task automatic count_rises(input int len);
      logic prev;
      prev = bitClk;
      cnt = 0;
      repeat (len) begin
         @(posedge clk);
         if (bitClk === 1'b1 && prev !== 1'b1) cnt++;
         prev = bitClk;
      end
   endtask : count_rises

   task automatic send(input logic [7:0] d, input logic [7:0] c);
      byteData <= d;
      byteClk <= c;
      sendByte <= 1'b1;
      @(posedge clk);
      sendByte <= 1'b0;
   endtask : send

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      apb(1'b0, mfm_pkg::ADDR_STATUS, 32'h0, 4'hF);
      check(rd, 32'h0);
      apb(1'b0, 12'hFFC, 32'h0, 4'hF);
      check({31'h0, e}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         w = $random(seed);
         apb(1'b1, mfm_pkg::ADDR_CTRL, w, 4'hF);
         apb(1'b0, mfm_pkg::ADDR_CTRL, 32'h0, 4'hF);
         check(rd, w & 32'h3);
      end
      ctrl(2'b00);
      apb(1'b1, mfm_pkg::ADDR_CTRL, 32'h3, 4'hE);
      apb(1'b1, mfm_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 4'hF);
      apb(1'b0, mfm_pkg::ADDR_CTRL, 32'h0, 4'hF);
      check({rd[30:0], e}, 32'h0);
      for (int r = 0; r < 3; r++) begin
         streamOn <= 1'b1;
         count_rises(300);
         check(cnt, 0);
         streamOn <= 1'b0;
         repeat (100) @(posedge clk);
         ctrl(2'b10);
         streamOn <= 1'b1;
         repeat (200) @(posedge clk);
         check(steady_run_detect, 1'b0);
         wait_for(steady_run_detect, 1'b1, 300);
         check(32'(cnt < 300), 32'h1);
         ctrl(2'b11);
         wait_for(divider_hold_n, 1'b1, 100);
         check(32'(cnt < 100), 32'h1);
         count_rises(400);
         check(32'(cnt >= 19 && cnt <= 21), 32'h1);
         repeat (8) begin
            repeat (17) @(posedge clk);
            check({separated_read_data_n, separated_clock_bits_n}, 2'b10);
         end
         send(mfm_pkg::MARK_DATA, 8'h0E);
         wait_for(mark_found_n, 1'b0, 400);
         check(cnt, 400);
         send(mfm_pkg::MARK_DATA, mfm_pkg::MARK_CLOCK);
         wait_for(mark_found_n, 1'b0, 400);
         check(32'(cnt < 400), 32'h1);
         wait_for(mark_found_n, 1'b1, 300);
         check(cnt, 300);
         apb(1'b0, mfm_pkg::ADDR_STATUS, 32'h0, 4'hF);
         check(rd[3:1], 3'b111);
         apb(1'b0, mfm_pkg::ADDR_SHIFT, 32'h0, 4'hF);
         check(rd[15:8], mfm_pkg::MARK_CLOCK);
         ctrl(2'b10);
         repeat (3) @(posedge clk);
         check({mark_found_n, divider_hold_n, bitClk}, 3'b100);
         count_rises(200);
         check(cnt, 0);
         ctrl(2'b00);
         repeat (3) @(posedge clk);
         check(steady_run_detect, 1'b0);
      end
      report_and_stop();
   end
endmodule : mfm_read_separator_mark_detect_tb_top

bind mfm_read_separator mfm_properties u_props (.clk, .reset, .bitClk,
   .bitClkN, .separated_read_data_n, .separated_clock_bits_n,
   .mark_found_n, .divider_hold_n);
